/* File: lmb_defines.svh */
// Constant offsets, field positions, reset values and timing counts of the map/branch unit.
`ifndef LMB_DEFINES_SVH
`define LMB_DEFINES_SVH

// Number of program execution engines and of LED driver outputs.
`define LMB_ENGINES 3
`define LMB_LEDS 9
// Program memory rows; row addresses and step numbers run 0 to 95.
`define LMB_ROWS 96
`define LMB_LAST_ROW 7'h5f

// Register offsets seen by the host port.
`define LMB_REG_STATUS 8'h3a
`define LMB_REG_FADER_ONE 8'h48
`define LMB_REG_FADER_TWO 8'h49
`define LMB_REG_FADER_THREE 8'h4a

// Reset values of the host registers.
`define LMB_STATUS_RESET 8'h00
`define LMB_FADER_RESET 8'h00
// Value written to the PWM register of a mapped driver by an end with reset.
`define LMB_PWM_ZERO 8'h00

// Engine interrupt bits sit at the bottom of the status register, engine 1 in bit 0.
`define LMB_STATUS_ENG_LSB 0

// Instruction time: sixteen cycles of the 32768 Hz engine clock.
`define LMB_CLK_HZ 50000000
`define LMB_ENG_CLK_HZ 32768
`define LMB_INSTR_ENG_CYCLES 16
// Least time, so the cycle count rounds up.
`define LMB_INSTR_CYCLES \
  ((`LMB_CLK_HZ * `LMB_INSTR_ENG_CYCLES + `LMB_ENG_CLK_HZ - 1) / `LMB_ENG_CLK_HZ)
// Width of the instruction timer; 24415 cycles fit in 15 bits.
`define LMB_WAIT_W 15

`endif

/* File: lmb_pkg.sv */
// Types shared by the map/branch unit and its helpers.
package lmb_pkg;

  // Decoded instruction kinds handed to the unit by the fetch stage.
  typedef enum logic [3:0] {
    LMB_OP_NONE,
    LMB_OP_MAP_PREV,
    LMB_OP_POINTER_STEP_BACK,
    LMB_OP_MAP_ADDR,
    LMB_OP_POINTER_JUMP,
    LMB_OP_TABLE_FIRST_ROW_SET,
    LMB_OP_TABLE_LAST_ROW_SET,
    LMB_OP_BRANCH_IMM,
    LMB_OP_BRANCH_VAR,
    LMB_OP_END_INT,
    LMB_OP_PWM_PUSH
  } lmb_op_t;

  // Row address or program counter value.
  typedef logic [6:0] lmb_row_t;

  // Engine execution state.
  typedef enum logic [1:0] {
    LMB_ENG_RUN,
    LMB_ENG_BUSY,
    LMB_ENG_HALT
  } lmb_eng_state_t;

endpackage : lmb_pkg

/* File: lmb_wait_if.sv */
// Handshake between an engine and its instruction timer.
`timescale 1ns/10ps
`default_nettype none

interface lmb_wait_if;
  logic start; // One-cycle pulse that arms the timer.
  logic busy; // High while the timer runs.
  logic done; // One-cycle pulse in the first cycle after busy falls.

  // The engine side arms the timer and watches it.
  modport user (output start, input busy, input done);
  // The timer side counts.
  modport timer (input start, output busy, output done);
endinterface : lmb_wait_if

`default_nettype wire

/* File: lmb_wait_timer.sv */
// Instruction timer that stretches one instruction over its fixed execution time.
`timescale 1ns/10ps
`default_nettype none

`include "lmb_defines.svh"

module lmb_wait_timer #(
  parameter int unsigned CYCLES = `LMB_INSTR_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  lmb_wait_if.timer wt
);

  logic [`LMB_WAIT_W-1:0] left_reg; // Cycles still to run.
  logic done_reg; // Pulse in the first cycle with the count at zero.

  // Load on start, count down to zero otherwise.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      left_reg <= '0;
    end else if (wt.start) begin
      left_reg <= CYCLES[`LMB_WAIT_W-1:0];
    end else if (left_reg != '0) begin
      left_reg <= left_reg - 1'b1;
    end
  end

  // The done pulse marks the cycle in which the count runs out.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (left_reg == `LMB_WAIT_W'(1)) && !wt.start;
    end
  end

  assign wt.busy = (left_reg != '0);
  assign wt.done = done_reg;

endmodule : lmb_wait_timer

`default_nettype wire

/* File: lmb_row_step.sv */
// Steps a mapping table row back by one, wrapping from the first row to the last.
`timescale 1ns/10ps
`default_nettype none

module lmb_row_step (
  input wire lmb_pkg::lmb_row_t cur_i,
  input wire lmb_pkg::lmb_row_t first_i,
  input wire lmb_pkg::lmb_row_t last_i,
  output lmb_pkg::lmb_row_t prev_o
);

  // At the table start the step wraps to the table end, else it just decrements.
  assign prev_o = (cur_i == first_i) ? last_i : lmb_pkg::lmb_row_t'(cur_i - 7'h01);

endmodule : lmb_row_step

`default_nettype wire

/* File: lmb_ctrl.sv */
// Map and branch instruction unit of the three program execution engines.
`timescale 1ns/10ps
`default_nettype none

`include "lmb_defines.svh"

// How it works
// - Map-previous activates preceding row, wrapping start to end.
// - No PWM push to new mapping until PWM op.
// - Released outputs follow their own PWM register.
// - Pointer step back moves only the index.
// - Map-address loads index and activates that row.
// - Pointer jump loads index without activating anything.
// - Branch loads program counter with step number.
// - Immediate count sets repeats; zero loops forever.
// - Variable count selects A, B, C or D.
// - Every loop keeps its own count, unlimited nesting.
// - Branch occupies sixteen engine clock cycles.
// - Interrupt pulls pin low and sets status bit.
// - Host read of status clears pending interrupts.
// - Interrupt field zero raises nothing; PWM follows reset field.
// - Interrupt field one clears counter and interrupts.
// - Reset field zero clears counter and halts.
// - Reset field one also zeroes mapped PWM registers.
// - Reset field one zeroes the engine's master fader.
// - Three independent engines, each mappable to nine LEDs.
// - Table first and last rows bound backward stepping.
module lmb_ctrl #(
  parameter int unsigned INSTR_CYCLES = `LMB_INSTR_CYCLES
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [1:0] instr_engine_i,
  input wire lmb_pkg::lmb_op_t instr_op_i,
  input wire logic [6:0] instr_addr_i,
  input wire logic [5:0] instr_loop_i,
  input wire logic [1:0] instr_var_sel_i,
  input wire logic instr_int_i,
  input wire logic instr_reset_i,
  input wire logic [2:0] engine_start_i,
  input wire logic [23:0] var_a_i,
  input wire logic [23:0] var_b_i,
  input wire logic [7:0] var_c_i,
  input wire logic [7:0] var_d_i,
  input wire logic [26:0] engine_leds_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic int_n_o,
  output logic [20:0] pc_o,
  output logic [20:0] index_o,
  output logic [20:0] active_row_o,
  output logic [2:0] map_live_o,
  output logic [2:0] busy_o,
  output logic [2:0] halted_o,
  output logic [8:0] led_engine_drive_o,
  output logic [8:0] pwm_clear_o,
  output logic [23:0] fader_o
);

  // Per-engine events gathered for the shared registers.
  logic [2:0] irq_set; // Completion of an end with interrupt.
  logic [2:0] fader_zero; // Completion of an end with reset.
  logic [2:0] pwm_drive; // Mapping live and PWM push allowed.

  // Host-visible registers.
  logic [7:0] status_reg; // Engine interrupt bits.
  logic [7:0] status_next; // Next status value.
  logic [7:0] fader_one_reg, fader_two_reg, fader_three_reg; // Master faders of engines 1 to 3.

  genvar e;
  generate
    for (e = 0; e < `LMB_ENGINES; e++) begin : g_eng
      // Every engine owns its own copy of all of this state.
      lmb_pkg::lmb_row_t pc_reg; // Program counter.
      lmb_pkg::lmb_row_t idx_reg; // Mapping table index pointer.
      lmb_pkg::lmb_row_t act_reg; // Active mapping row.
      lmb_pkg::lmb_row_t first_reg, last_reg; // Mapping table first and last rows.
      lmb_pkg::lmb_row_t idx_prev, act_prev; // Index and active row stepped back.
      lmb_pkg::lmb_eng_state_t state_reg; // Run, timed or halted.
      logic map_live_reg; // A mapping row is active.
      logic hold_reg; // New mapping waits for a PWM instruction.
      logic end_int_reg, end_rst_reg; // Interrupt and reset fields of a pending end.
      logic end_pend_reg; // A timed end instruction is running.
      logic [`LMB_ROWS-1:0] loop_live_reg; // Loop armed at this branch row.
      logic [5:0] loop_left_mem [0:`LMB_ROWS-1]; // Jumps still to do per branch row.
      logic take, timed; // Instruction accepted this cycle, and whether it uses the timer.
      logic [7:0] var_val; // Selected loop count variable.
      logic [5:0] count, left; // Loop count of this branch and jumps still stored for its row.
      logic br_jump, br_arm, br_done; // Branch jumps, arms a counted loop, or falls through.
      lmb_pkg::lmb_row_t pc_inc; // Program counter plus one.
      lmb_wait_if wt ();

      // A halted or timed engine ignores the instruction port.
      assign take = instr_valid_i && (instr_engine_i == 2'(e))
                    && (state_reg == lmb_pkg::LMB_ENG_RUN);
      assign timed = take && ((instr_op_i == lmb_pkg::LMB_OP_BRANCH_IMM)
                    || (instr_op_i == lmb_pkg::LMB_OP_BRANCH_VAR)
                    || (instr_op_i == lmb_pkg::LMB_OP_END_INT));
      assign wt.start = timed;
      assign pc_inc = (pc_reg == `LMB_LAST_ROW) ? 7'h00 : lmb_pkg::lmb_row_t'(pc_reg + 7'h01);

      // Backward steps of the active row and of the index use two copies of one helper.
      lmb_row_step u_act_step (.cur_i(act_reg), .first_i(first_reg), .last_i(last_reg),
        .prev_o(act_prev));
      lmb_row_step u_idx_step (.cur_i(idx_reg), .first_i(first_reg), .last_i(last_reg),
        .prev_o(idx_prev));

      // Each timed instruction lasts sixteen engine clock cycles.
      lmb_wait_timer #(.CYCLES(INSTR_CYCLES)) u_timer (.clock_i(clock_i), .resetn_i(resetn_i),
        .wt(wt));

      // Loop count variable: A, B, C or D.
      always_comb begin
        unique case (instr_var_sel_i)
          2'd0: var_val = var_a_i[e*8 +: 8];
          2'd1: var_val = var_b_i[e*8 +: 8];
          2'd2: var_val = var_c_i;
          2'd3: var_val = var_d_i;
        endcase
      end

      // Branch decision. A loop count is stored per branch row, so nested
      // loops never share a counter; the cost is one small word per row.
      always_comb begin
        count = (instr_op_i == lmb_pkg::LMB_OP_BRANCH_VAR) ? var_val[5:0] : instr_loop_i;
        left = loop_left_mem[pc_reg];
        br_jump = 1'b0;
        br_arm = 1'b0;
        br_done = 1'b0;
        if (count == 6'h00) begin
          br_jump = 1'b1;
        end else if (!loop_live_reg[pc_reg]) begin
          br_jump = 1'b1;
          br_arm = 1'b1;
        end else if (left == 6'h00) begin
          br_done = 1'b1;
        end else begin
          br_jump = 1'b1;
        end
      end

      // Per-row loop counters, armed on the first pass and freed at the end.
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          loop_live_reg <= '0;
        end else if (timed && (instr_op_i != lmb_pkg::LMB_OP_END_INT)) begin
          if (br_arm) begin
            loop_live_reg[pc_reg] <= 1'b1;
          end else if (br_done) begin
            loop_live_reg[pc_reg] <= 1'b0;
          end
        end
      end

      // Counter storage holds no reset; a row is only read while armed.
      always_ff @(posedge clock_i) begin
        if (timed && (instr_op_i != lmb_pkg::LMB_OP_END_INT) && (count != 6'h00)) begin
          if (br_arm) begin
            loop_left_mem[pc_reg] <= count - 6'h01;
          end else if (!br_done) begin
            loop_left_mem[pc_reg] <= left - 6'h01;
          end
        end
      end

      // Program counter: branch target, cleared by an end, else next step.
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          pc_reg <= 7'h00;
        end else if (take) begin
          unique case (instr_op_i)
            lmb_pkg::LMB_OP_BRANCH_IMM, lmb_pkg::LMB_OP_BRANCH_VAR: begin
              pc_reg <= br_jump ? instr_addr_i : pc_inc;
            end
            lmb_pkg::LMB_OP_END_INT: pc_reg <= 7'h00;
            default: pc_reg <= pc_inc;
          endcase
        end
      end

      // Execution state: timed instructions stall the engine, an end halts it.
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          state_reg <= lmb_pkg::LMB_ENG_RUN;
        end else begin
          unique case (state_reg)
            lmb_pkg::LMB_ENG_RUN: if (timed) begin
              state_reg <= lmb_pkg::LMB_ENG_BUSY;
            end
            lmb_pkg::LMB_ENG_BUSY: if (wt.done) begin
              state_reg <= end_pend_reg ? lmb_pkg::LMB_ENG_HALT : lmb_pkg::LMB_ENG_RUN;
            end
            lmb_pkg::LMB_ENG_HALT: if (engine_start_i[e]) begin
              state_reg <= lmb_pkg::LMB_ENG_RUN;
            end
            default: state_reg <= lmb_pkg::LMB_ENG_RUN;
          endcase
        end
      end

      // Fields of a running end instruction, acted on when it completes.
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          end_pend_reg <= 1'b0;
          end_int_reg <= 1'b0;
          end_rst_reg <= 1'b0;
        end else if (timed) begin
          end_pend_reg <= (instr_op_i == lmb_pkg::LMB_OP_END_INT);
          end_int_reg <= instr_int_i;
          end_rst_reg <= instr_reset_i;
        end else if (wt.done) begin
          end_pend_reg <= 1'b0;
        end
      end

      // Interrupt field zero leaves the interrupt alone; reset field zero leaves every PWM value alone.
      assign irq_set[e] = wt.done && end_pend_reg && end_int_reg;
      assign fader_zero[e] = wt.done && end_pend_reg && end_rst_reg;

      // Mapping table bounds, index pointer and active row.
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          idx_reg <= 7'h00;
          act_reg <= 7'h00;
          first_reg <= 7'h00;
          last_reg <= 7'h00;
          map_live_reg <= 1'b0;
        end else if (take) begin
          unique case (instr_op_i)
            lmb_pkg::LMB_OP_MAP_PREV: begin
              act_reg <= act_prev;
              idx_reg <= act_prev;
              map_live_reg <= 1'b1;
            end
            lmb_pkg::LMB_OP_POINTER_STEP_BACK: idx_reg <= idx_prev;
            lmb_pkg::LMB_OP_MAP_ADDR: begin
              idx_reg <= instr_addr_i;
              act_reg <= instr_addr_i;
              map_live_reg <= 1'b1;
            end
            lmb_pkg::LMB_OP_POINTER_JUMP: idx_reg <= instr_addr_i;
            lmb_pkg::LMB_OP_TABLE_FIRST_ROW_SET: first_reg <= instr_addr_i;
            lmb_pkg::LMB_OP_TABLE_LAST_ROW_SET: last_reg <= instr_addr_i;
            default: ;
          endcase
        end
      end

      // A newly activated row holds off PWM pushes until a PWM instruction.
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          hold_reg <= 1'b0;
        end else if (take && ((instr_op_i == lmb_pkg::LMB_OP_MAP_PREV)
                   || (instr_op_i == lmb_pkg::LMB_OP_MAP_ADDR))) begin
          hold_reg <= 1'b1;
        end else if (take && (instr_op_i == lmb_pkg::LMB_OP_PWM_PUSH)) begin
          hold_reg <= 1'b0;
        end
      end

      assign pwm_drive[e] = map_live_reg && !hold_reg;

      // Per-engine observation outputs come from engine flip-flops; busy and halted are decoded from the state register.
      assign pc_o[e*7 +: 7] = pc_reg;
      assign index_o[e*7 +: 7] = idx_reg;
      assign active_row_o[e*7 +: 7] = act_reg;
      assign map_live_o[e] = map_live_reg;
      assign halted_o[e] = (state_reg == lmb_pkg::LMB_ENG_HALT);
      assign busy_o[e] = (state_reg == lmb_pkg::LMB_ENG_BUSY);
    end
  endgenerate

  // A status read clears only the bits it saw set; a new event wins.
  always_comb begin
    status_next = status_reg;
    if (reg_rd_i && (reg_addr_i == `LMB_REG_STATUS)) begin
      status_next = 8'h00;
    end
    status_next[`LMB_STATUS_ENG_LSB +: 3] = status_next[`LMB_STATUS_ENG_LSB +: 3] | irq_set;
  end

  // Status register update.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      status_reg <= `LMB_STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // The pin is low while any bit is set, from the same edge that sets it.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= ~(|status_next);
    end
  end

  // Master faders: host writes, and an end with reset zeroes its own.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      fader_one_reg <= `LMB_FADER_RESET;
      fader_two_reg <= `LMB_FADER_RESET;
      fader_three_reg <= `LMB_FADER_RESET;
    end else begin
      if (fader_zero[0]) fader_one_reg <= 8'h00;
      else if (reg_wr_i && (reg_addr_i == `LMB_REG_FADER_ONE)) fader_one_reg <= reg_wdata_i;
      if (fader_zero[1]) fader_two_reg <= 8'h00;
      else if (reg_wr_i && (reg_addr_i == `LMB_REG_FADER_TWO)) fader_two_reg <= reg_wdata_i;
      if (fader_zero[2]) fader_three_reg <= 8'h00;
      else if (reg_wr_i && (reg_addr_i == `LMB_REG_FADER_THREE)) fader_three_reg <= reg_wdata_i;
    end
  end

  assign fader_o = {fader_three_reg, fader_two_reg, fader_one_reg};

  // Read data is captured on the read strobe; other offsets read zero.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `LMB_REG_STATUS: reg_rdata_o <= status_reg;
        `LMB_REG_FADER_ONE: reg_rdata_o <= fader_one_reg;
        `LMB_REG_FADER_TWO: reg_rdata_o <= fader_two_reg;
        `LMB_REG_FADER_THREE: reg_rdata_o <= fader_three_reg;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Per LED: driven by an engine only while mapped and released for PWM;
  // otherwise the driver keeps following its own PWM register.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      led_engine_drive_o <= '0;
      pwm_clear_o <= '0;
    end else begin
      for (int l = 0; l < `LMB_LEDS; l++) begin
        led_engine_drive_o[l] <= (engine_leds_i[l] && pwm_drive[0])
                              || (engine_leds_i[9 + l] && pwm_drive[1])
                              || (engine_leds_i[18 + l] && pwm_drive[2]);
        pwm_clear_o[l] <= (engine_leds_i[l] && fader_zero[0])
                       || (engine_leds_i[9 + l] && fader_zero[1])
                       || (engine_leds_i[18 + l] && fader_zero[2]);
      end
    end
  end

endmodule : lmb_ctrl

`default_nettype wire

/* File: lmb_host_model.sv */
// Host processor model that owns the register port and clears interrupts.
`timescale 1ns/10ps
`default_nettype none
module lmb_host_model (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  // The port is quiet from time zero.
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // One write strobe per access; released data is inverted so no stale copy lingers.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clock_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : wr
  // A status read is the only way this host clears pending interrupts.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clock_i);
    reg_rd_o <= 1'b0;
    @(negedge clock_i);
    d = reg_rdata_i;
  endtask : rd
endmodule : lmb_host_model
`default_nettype wire

/* File: lmb_ctrl_checker.sv */
// Port checker of the map and branch unit.
`timescale 1ns/10ps
`default_nettype none
module lmb_ctrl_checker #(
  parameter int unsigned INSTR_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [1:0] instr_engine_i,
  input wire lmb_pkg::lmb_op_t instr_op_i,
  input wire logic [6:0] instr_addr_i,
  input wire logic [5:0] instr_loop_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic int_n_o,
  input wire logic [20:0] pc_o,
  input wire logic [20:0] index_o,
  input wire logic [20:0] active_row_o,
  input wire logic [2:0] busy_o,
  input wire logic [2:0] halted_o
);
  // Engine 0 takes an instruction on this edge.
  wire logic go = instr_valid_i && instr_engine_i == 2'h0 && !busy_o[0] && !halted_o[0];
  logic [15:0] busy_cnt_reg; // Edges engine 0 has stayed busy; a counter avoids long repeats.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      busy_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_o[0] ? busy_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  AST_MAP_ADDR: assert property (go && instr_op_i == lmb_pkg::LMB_OP_MAP_ADDR |=>
    index_o[6:0] == $past(instr_addr_i) && active_row_o[6:0] == $past(instr_addr_i))
    else $error("map address not loaded");
  AST_JUMP: assert property (go && instr_op_i == lmb_pkg::LMB_OP_POINTER_JUMP |=>
    index_o[6:0] == $past(instr_addr_i) && $stable(active_row_o)) else $error("jump moved row");
  AST_STEP_BACK: assert property (go && instr_op_i == lmb_pkg::LMB_OP_POINTER_STEP_BACK |=>
    $stable(active_row_o)) else $error("step back moved row");
  AST_BRANCH_PC: assert property (go && instr_op_i == lmb_pkg::LMB_OP_BRANCH_IMM
    && instr_loop_i == 6'h00 |=> pc_o[6:0] == $past(instr_addr_i) && busy_o[0])
    else $error("branch target not loaded");
  AST_BRANCH_TIME: assert property ($fell(busy_o[0]) |->
    busy_cnt_reg == INSTR_CYCLES + 1) else $error("timed span wrong");
  AST_INT_FALL: assert property ($fell(int_n_o) |->
    (halted_o & ~$past(halted_o)) != 3'h0) else $error("interrupt without an end");
  AST_INT_RELEASE: assert property ($rose(int_n_o) |->
    $past(reg_rd_i) && $past(reg_addr_i) == 8'h3a) else $error("released without status read");
  AST_HALT_PC: assert property ($rose(halted_o[0]) |-> pc_o[6:0] == 7'h00)
    else $error("halted with pc set");
endmodule : lmb_ctrl_checker
bind lmb_ctrl lmb_ctrl_checker #(.INSTR_CYCLES(INSTR_CYCLES)) lmb_ctrl_checker_inst (
  .clock_i, .resetn_i, .instr_valid_i, .instr_engine_i, .instr_op_i, .instr_addr_i,
  .instr_loop_i, .reg_addr_i, .reg_rd_i, .int_n_o, .pc_o, .index_o, .active_row_o,
  .busy_o, .halted_o);
`default_nettype wire

/* File: lmb_ctrl_tb.sv */
// Self-checking testbench of the map and branch unit.
`timescale 1ns/10ps
`default_nettype none
module lmb_ctrl_tb;
  localparam int unsigned CYC = 20; // Short instruction time keeps the run brief.
  logic clock_i = 1'b0, resetn_i = 1'b0, instr_valid_i = 1'b0, instr_int_i = 1'b0;
  logic instr_reset_i = 1'b0, reg_wr_i, reg_rd_i, int_n_o;
  logic [1:0] instr_engine_i = 2'h0, instr_var_sel_i = 2'h0;
  lmb_pkg::lmb_op_t instr_op_i = lmb_pkg::LMB_OP_NONE;
  logic [6:0] instr_addr_i = 7'h00;
  logic [5:0] instr_loop_i = 6'h00;
  logic [2:0] engine_start_i = 3'h0, map_live_o, busy_o, halted_o;
  logic [23:0] var_a_i = 24'h00_0000, var_b_i = 24'h00_0000, fader_o;
  logic [7:0] var_c_i = 8'h00, var_d_i = 8'h00, reg_addr_i, reg_wdata_i, reg_rdata_o, rdv;
  logic [26:0] engine_leds_i = 27'h000_0005;
  logic [20:0] pc_o, index_o, active_row_o;
  logic [8:0] led_engine_drive_o, pwm_clear_o;
  int bad_count = 0;
  int checked = 0;
  lmb_ctrl #(.INSTR_CYCLES(CYC)) lmb_ctrl_inst (.clock_i, .resetn_i, .instr_valid_i,
    .instr_engine_i, .instr_op_i, .instr_addr_i, .instr_loop_i, .instr_var_sel_i, .instr_int_i,
    .instr_reset_i, .engine_start_i, .var_a_i, .var_b_i, .var_c_i, .var_d_i, .engine_leds_i,
    .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .int_n_o, .pc_o, .index_o,
    .active_row_o, .map_live_o, .busy_o, .halted_o, .led_engine_drive_o, .pwm_clear_o, .fader_o);
  lmb_host_model lmb_host_model_inst (.clock_i, .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    lmb_host_model_inst.rd(a, rdv);
    chk(rdv, exp);
  endtask : rdc
  // Valid is held for exactly the one edge that takes the instruction.
  task automatic ins(input logic [1:0] e, input lmb_pkg::lmb_op_t op, input logic [6:0] a,
      input logic [1:0] s = 2'h0, input logic it = 1'b0, input logic rs = 1'b0);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_engine_i <= e;
    instr_op_i <= op;
    instr_addr_i <= a;
    instr_var_sel_i <= s;
    instr_loop_i <= {4'h0, s};
    instr_int_i <= it;
    instr_reset_i <= rs;
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    @(negedge clock_i);
  endtask : ins
  task automatic idle(input int e);
    for (int n = 0; n < 3 * CYC && busy_o[e] !== 1'b0; n++) @(negedge clock_i);
    chk(busy_o[e], 1'b0);
  endtask : idle
  // Reset values, a read-only status write and an unmapped read.
  task automatic t_regs;
    chk(int_n_o, 1'b1);
    rdc(8'h48, 8'h00);
    rdc(8'h10, 8'h00);
    lmb_host_model_inst.wr(8'h48, 8'h55);
    lmb_host_model_inst.wr(8'h3a, 8'hff);
    rdc(8'h48, 8'h55);
    rdc(8'h3a, 8'h00);
  endtask : t_regs
  // Backward stepping wraps inside the table; pointer moves leave the mapping alone.
  task automatic t_map;
    ins(2'h0, lmb_pkg::LMB_OP_TABLE_FIRST_ROW_SET, 7'h0a);
    ins(2'h0, lmb_pkg::LMB_OP_TABLE_LAST_ROW_SET, 7'h0c);
    ins(2'h0, lmb_pkg::LMB_OP_MAP_ADDR, 7'h0a);
    ins(2'h0, lmb_pkg::LMB_OP_MAP_PREV, 7'h00);
    chk(active_row_o, 21'h00_000c);
    chk(map_live_o, 3'h1);
    ins(2'h0, lmb_pkg::LMB_OP_MAP_PREV, 7'h00);
    chk(active_row_o, 21'h00_000b);
    chk(led_engine_drive_o, 9'h000);
    ins(2'h0, lmb_pkg::LMB_OP_POINTER_STEP_BACK, 7'h00);
    chk(index_o, 21'h00_000a);
    ins(2'h0, lmb_pkg::LMB_OP_POINTER_JUMP, 7'h5f);
    chk(index_o, 21'h00_005f);
    chk(active_row_o, 21'h00_000b);
    ins(2'h0, lmb_pkg::LMB_OP_PWM_PUSH, 7'h00);
    @(negedge clock_i);
    chk(led_engine_drive_o, 9'h005);
  endtask : t_map
  // A busy engine ignores work; a self branch repeats as often as its selected count says.
  task automatic t_branch;
    ins(2'h0, lmb_pkg::LMB_OP_BRANCH_IMM, 7'h5f);
    chk(pc_o, 21'h00_005f);
    ins(2'h0, lmb_pkg::LMB_OP_MAP_ADDR, 7'h20);
    chk(active_row_o, 21'h00_000b);
    idle(0);
    @(posedge clock_i);
    var_a_i <= 24'h01_0000;
    var_b_i <= 24'h02_0000;
    var_c_i <= 8'h03;
    var_d_i <= 8'h04;
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < s + 2; k++) begin
        ins(2'h2, lmb_pkg::LMB_OP_BRANCH_VAR, 7'(s), 2'(s));
        chk(pc_o[20:14], 7'(s + (k > s)));
        idle(2);
      end
    end
  endtask : t_branch
  // End with interrupt and reset, the clearing read, then a restart.
  task automatic t_end;
    @(posedge clock_i);
    engine_leds_i <= 27'h000_0211;
    ins(2'h0, lmb_pkg::LMB_OP_END_INT, 7'h00, 2'h0, 1'b1, 1'b1);
    idle(0);
    chk(int_n_o, 1'b0);
    chk(halted_o, 3'h1);
    chk(pc_o[6:0], 7'h00);
    chk(fader_o, 24'h00_0000);
    chk(pwm_clear_o, 9'h011);
    rdc(8'h3a, 8'h01);
    chk(int_n_o, 1'b1);
    rdc(8'h3a, 8'h00);
    @(posedge clock_i);
    engine_start_i <= 3'h1;
    @(posedge clock_i);
    engine_start_i <= 3'h0;
    lmb_host_model_inst.wr(8'h49, 8'h33);
    ins(2'h1, lmb_pkg::LMB_OP_END_INT, 7'h00);
    idle(1);
    chk(int_n_o, 1'b1);
    chk(halted_o, 3'h2);
    chk(fader_o, 24'h00_3300);
    chk(pwm_clear_o, 9'h000);
  endtask : t_end
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    t_regs;
    t_map;
    t_branch;
    t_end;
    give_verdict;
  end
  // The tests need well under a thousand cycles; this limit only catches a hang.
  initial begin
    #200000;
    bad_count++;
    $display("BAD at %0t: run timed out", $time);
    give_verdict;
  end
endmodule : lmb_ctrl_tb
`default_nettype wire
